// *** rtl/tmr_consts.svh ***
// Register addresses, field positions, reset values and timebase counts for the timer pair
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_ADDR_T2_CTRL 8'hC8
`define TMR_ADDR_T2_RCAP_LO 8'hCA
`define TMR_ADDR_T2_RCAP_HI 8'hCB
`define TMR_ADDR_T2_LO 8'hCC
`define TMR_ADDR_T2_HI 8'hCD
`define TMR_ADDR_CLK_CTRL 8'h8E
`define TMR_ADDR_T3_CTRL 8'h91
`define TMR_ADDR_T3_RLD_LO 8'h92
`define TMR_ADDR_T3_RLD_HI 8'h93
`define TMR_ADDR_T3_LO 8'h94
`define TMR_ADDR_T3_HI 8'h95
`define TMR_T2_OVF_BIT 7
`define TMR_T2_EXT_BIT 6
`define TMR_T2_RCLK_BIT 5
`define TMR_T2_TRANSMIT_BAUD_SOURCE_SELECT_BIT 4
`define TMR_T2_EXEN_BIT 3
`define TMR_T2_RUN_BIT 2
`define TMR_T2_CNT_BIT 1
`define TMR_T2_CP_BIT 0
`define TMR_CLK_T2_DIV_BIT 5
`define TMR_T3_RUN_BIT 2
`define TMR_T3_DIV_BIT 0
`define TMR_RESET_BYTE 8'h00
`define TMR_RESET_WORD 16'h0000
`define TMR_COUNT_MAX 16'hFFFF
`define TMR_COUNT_ONE 16'h0001
`define TMR_PRESCALE_LAST 4'hB
`define TMR_PRESCALE_ONE 4'h1
`define TMR_PRESCALE_ZERO 4'h0
`define TMR_SYNC_IDLE 3'h7
`endif

// *** rtl/tmr_pkg.sv ***
// Types shared by the timer pair
package tmr_pkg;
   typedef enum logic [3:0] {
      TMR_MODE_OFF = 4'b0001,
      TMR_MODE_CAPTURE = 4'b0010,
      TMR_MODE_RELOAD = 4'b0100,
      TMR_MODE_BAUD = 4'b1000
   } tmr_mode_type;
endpackage

// *** rtl/tmr_t3_if.sv ***
// Carrier between the timer pair top and the third timer
`timescale 1ns/1ps
interface tmr_t3_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic tick12;
   logic [7:0] rd_ctrl;
   logic [7:0] rd_lo;
   logic [7:0] rd_hi;
   logic [7:0] rd_rld_lo;
   logic [7:0] rd_rld_hi;
   logic ovf;
   modport ctl (output wr_en, wr_addr, wr_data, tick12,
      input rd_ctrl, rd_lo, rd_hi, rd_rld_lo, rd_rld_hi, ovf);
   modport tmr (input wr_en, wr_addr, wr_data, tick12,
      output rd_ctrl, rd_lo, rd_hi, rd_rld_lo, rd_rld_hi, ovf);
endinterface

// *** rtl/tmr_third.sv ***
// Third timer: 16-bit auto-reload timer on the divided system clock
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_third
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   tmr_t3_if.tmr bus
);
   logic [7:0] ctrl, next_ctrl;
   logic [15:0] count, next_count;
   logic [15:0] reload, next_reload;
   logic ovf, next_ovf;
   logic step;

   // Next count, reload and overflow pulse
   always_comb begin
      next_ctrl = ctrl;
      next_count = count;
      next_reload = reload;
      step = 1'b0;
      // Divide by one or twelve, system clock only, no counter input
      if (ctrl[`TMR_T3_RUN_BIT]) begin
         step = ctrl[`TMR_T3_DIV_BIT] ? 1'b1 : bus.tick12;
      end
      next_ovf = step && (count == `TMR_COUNT_MAX);
      if (step) begin
         // Always reloads on overflow
         next_count = next_ovf ? reload : count + `TMR_COUNT_ONE;
      end
      // Software access to the byte pair
      if (bus.wr_en) begin
         unique case (bus.wr_addr)
            `TMR_ADDR_T3_CTRL: next_ctrl = bus.wr_data;
            `TMR_ADDR_T3_LO: next_count[7:0] = bus.wr_data;
            `TMR_ADDR_T3_HI: next_count[15:8] = bus.wr_data;
            `TMR_ADDR_T3_RLD_LO: next_reload[7:0] = bus.wr_data;
            `TMR_ADDR_T3_RLD_HI: next_reload[15:8] = bus.wr_data;
            default: next_ctrl = ctrl;
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `TMR_RESET_BYTE;
         count <= `TMR_RESET_WORD;
         reload <= `TMR_RESET_WORD;
         ovf <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         count <= next_count;
         reload <= next_reload;
         ovf <= next_ovf;
      end
   end

   // Readback and event out
   assign bus.rd_ctrl = ctrl;
   assign bus.rd_lo = count[7:0];
   assign bus.rd_hi = count[15:8];
   assign bus.rd_rld_lo = reload[7:0];
   assign bus.rd_rld_hi = reload[15:8];
   assign bus.ovf = ovf;
endmodule

// *** rtl/tmr_pair.sv ***
// Timer pair top: second timer with capture, reload and baud modes, plus third timer
`timescale 1ns/1ps
`include "tmr_consts.svh"
// Summary of operation
// - Timer mode counts divided system clock
// - Counter mode counts external falling edges
// - Mode from run, baud selects, capture bit
// - Overflow flag set on wrap, capture/reload
// - Trigger edge captures or reloads; overflow reloads except in capture mode
// - Baud mode: reload, no overflow flag, clock/2
// - Third timer is 16 bits in two bytes
// - Third timer clock divided by one/twelve
// - Third timer always auto-reloads
// - Third timer has no counter mode
// - Third timer event starts ADC, times SMBus
module tmr_pair
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic external_count_input,
   input wire logic external_trigger_input,
   output logic second_timer_irq,
   output logic uart_rx_baud_tick,
   output logic uart_tx_baud_tick,
   output logic adc_start_trigger,
   output logic smbus_timing_tick
);
   tmr_t3_if t3 ();

   logic [7:0] second_timer_control_reg, next_ctrl;
   logic [7:0] clock_control_reg, next_clk_ctrl;
   logic [15:0] count, next_count;
   logic [15:0] reload_capture, next_reload_capture;
   logic [3:0] prescale, next_prescale;
   logic tick12, next_tick12;
   logic half, next_half;
   logic [2:0] cnt_sync, next_cnt_sync;
   logic [2:0] trg_sync, next_trg_sync;
   logic cnt_level, next_cnt_level;
   logic trg_level, next_trg_level;
   logic [7:0] next_rdata;
   logic next_irq, next_rx_tick, next_tx_tick;
   logic adc_q, smb_q;
   logic cnt_fall, trg_fall, step, wrap, trig;
   tmr_mode_type mode;

   logic second_timer_overflow_flag;
   logic second_timer_external_flag;
   logic transmit_baud_source_select;
   logic receive_baud_source_select;
   logic external_trigger_enable;
   logic second_timer_run;
   logic counter_select;
   logic capture_reload_select;
   logic second_timer_clock_divide;

   assign second_timer_overflow_flag = second_timer_control_reg[`TMR_T2_OVF_BIT];
   assign second_timer_external_flag = second_timer_control_reg[`TMR_T2_EXT_BIT];
   assign receive_baud_source_select = second_timer_control_reg[`TMR_T2_RCLK_BIT];
   assign transmit_baud_source_select = second_timer_control_reg[`TMR_T2_TRANSMIT_BAUD_SOURCE_SELECT_BIT];
   assign external_trigger_enable = second_timer_control_reg[`TMR_T2_EXEN_BIT];
   assign second_timer_run = second_timer_control_reg[`TMR_T2_RUN_BIT];
   assign counter_select = second_timer_control_reg[`TMR_T2_CNT_BIT];
   assign capture_reload_select = second_timer_control_reg[`TMR_T2_CP_BIT];
   assign second_timer_clock_divide = clock_control_reg[`TMR_CLK_T2_DIV_BIT];

   // Third timer and its register port
   tmr_third u_third (
      .clk(clk),
      .rst_n(rst_n),
      .bus(t3.tmr)
   );
   assign t3.wr_en = sfr_wr;
   assign t3.wr_addr = sfr_addr;
   assign t3.wr_data = sfr_wdata;
   assign t3.tick12 = tick12;

   // Pin synchronisers, prescaler and mode decode
   always_comb begin
      next_cnt_sync = {cnt_sync[1:0], external_count_input};
      next_trg_sync = {trg_sync[1:0], external_trigger_input};
      next_cnt_level = (cnt_sync[1] == cnt_sync[2]) ? cnt_sync[1] : cnt_level;
      next_trg_level = (trg_sync[1] == trg_sync[2]) ? trg_sync[1] : trg_level;
      cnt_fall = cnt_level && !next_cnt_level;
      trg_fall = trg_level && !next_trg_level;
      next_tick12 = (prescale == `TMR_PRESCALE_LAST);
      next_prescale = next_tick12 ? `TMR_PRESCALE_ZERO : prescale + `TMR_PRESCALE_ONE;
      next_half = !half;
      // Off, baud, capture or reload
      if (!second_timer_run) begin
         mode = TMR_MODE_OFF;
      end else if (receive_baud_source_select || transmit_baud_source_select) begin
         mode = TMR_MODE_BAUD;
      end else if (capture_reload_select) begin
         mode = TMR_MODE_CAPTURE;
      end else begin
         mode = TMR_MODE_RELOAD;
      end
   end

   // Second timer counting and event logic
   always_comb begin
      next_ctrl = second_timer_control_reg;
      next_clk_ctrl = clock_control_reg;
      next_count = count;
      next_reload_capture = reload_capture;
      step = 1'b0;
      if (mode != TMR_MODE_OFF) begin
         if (counter_select) begin
            step = cnt_fall;
         end else if (mode == TMR_MODE_BAUD) begin
            step = half;
         end else begin
            step = second_timer_clock_divide ? 1'b1 : tick12;
         end
      end
      wrap = step && (count == `TMR_COUNT_MAX);
      trig = trg_fall && external_trigger_enable && (mode != TMR_MODE_OFF);
      if (step) begin
         // Reload on overflow except in capture mode
         next_count = (wrap && mode != TMR_MODE_CAPTURE) ? reload_capture
            : count + `TMR_COUNT_ONE;
      end
      // Trigger edge captures or reloads
      if (trig && mode == TMR_MODE_CAPTURE) begin
         next_reload_capture = count;
      end
      if (trig && mode == TMR_MODE_RELOAD) begin
         next_count = reload_capture;
      end
      // Software writes; flags take set over clear
      if (sfr_wr) begin
         unique case (sfr_addr)
            `TMR_ADDR_T2_CTRL: next_ctrl = sfr_wdata;
            `TMR_ADDR_CLK_CTRL: next_clk_ctrl = sfr_wdata;
            `TMR_ADDR_T2_LO: next_count[7:0] = sfr_wdata;
            `TMR_ADDR_T2_HI: next_count[15:8] = sfr_wdata;
            `TMR_ADDR_T2_RCAP_LO: next_reload_capture[7:0] = sfr_wdata;
            `TMR_ADDR_T2_RCAP_HI: next_reload_capture[15:8] = sfr_wdata;
            default: next_clk_ctrl = clock_control_reg;
         endcase
      end
      // Overflow flag only in capture and reload modes
      if (wrap && (mode == TMR_MODE_CAPTURE || mode == TMR_MODE_RELOAD)) begin
         next_ctrl[`TMR_T2_OVF_BIT] = 1'b1;
      end
      if (trig) begin
         next_ctrl[`TMR_T2_EXT_BIT] = 1'b1;
      end
      next_irq = next_ctrl[`TMR_T2_OVF_BIT] || next_ctrl[`TMR_T2_EXT_BIT];
      // Overflows feed the serial shift clock
      next_rx_tick = wrap && mode == TMR_MODE_BAUD && receive_baud_source_select;
      next_tx_tick = wrap && mode == TMR_MODE_BAUD && transmit_baud_source_select;
   end

   // Read mux, registered; unmapped reads zero
   always_comb begin
      unique case (sfr_addr)
         `TMR_ADDR_T2_CTRL: next_rdata = second_timer_control_reg;
         `TMR_ADDR_CLK_CTRL: next_rdata = clock_control_reg;
         `TMR_ADDR_T2_LO: next_rdata = count[7:0];
         `TMR_ADDR_T2_HI: next_rdata = count[15:8];
         `TMR_ADDR_T2_RCAP_LO: next_rdata = reload_capture[7:0];
         `TMR_ADDR_T2_RCAP_HI: next_rdata = reload_capture[15:8];
         `TMR_ADDR_T3_CTRL: next_rdata = t3.rd_ctrl;
         `TMR_ADDR_T3_LO: next_rdata = t3.rd_lo;
         `TMR_ADDR_T3_HI: next_rdata = t3.rd_hi;
         `TMR_ADDR_T3_RLD_LO: next_rdata = t3.rd_rld_lo;
         `TMR_ADDR_T3_RLD_HI: next_rdata = t3.rd_rld_hi;
         default: next_rdata = `TMR_RESET_BYTE;
      endcase
   end

   // Registers of the top
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         second_timer_control_reg <= `TMR_RESET_BYTE;
         clock_control_reg <= `TMR_RESET_BYTE;
         count <= `TMR_RESET_WORD;
         reload_capture <= `TMR_RESET_WORD;
         prescale <= `TMR_PRESCALE_ZERO;
         tick12 <= 1'b0;
         half <= 1'b0;
         cnt_sync <= `TMR_SYNC_IDLE;
         trg_sync <= `TMR_SYNC_IDLE;
         cnt_level <= 1'b1;
         trg_level <= 1'b1;
         sfr_rdata <= `TMR_RESET_BYTE;
         second_timer_irq <= 1'b0;
         uart_rx_baud_tick <= 1'b0;
         uart_tx_baud_tick <= 1'b0;
         adc_q <= 1'b0;
         smb_q <= 1'b0;
      end else begin
         second_timer_control_reg <= next_ctrl;
         clock_control_reg <= next_clk_ctrl;
         count <= next_count;
         reload_capture <= next_reload_capture;
         prescale <= next_prescale;
         tick12 <= next_tick12;
         half <= next_half;
         cnt_sync <= next_cnt_sync;
         trg_sync <= next_trg_sync;
         cnt_level <= next_cnt_level;
         trg_level <= next_trg_level;
         sfr_rdata <= next_rdata;
         second_timer_irq <= next_irq;
         uart_rx_baud_tick <= next_rx_tick;
         uart_tx_baud_tick <= next_tx_tick;
         adc_q <= t3.ovf;
         smb_q <= t3.ovf;
      end
   end

   assign adc_start_trigger = adc_q;
   assign smbus_timing_tick = smb_q;
endmodule

// *** verif/tmr_chk.sv ***
// Port checker bound to the timer pair top
`timescale 1ns/1ps
module tmr_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic external_count_input,
   input wire logic external_trigger_input,
   input wire logic second_timer_irq,
   input wire logic uart_rx_baud_tick,
   input wire logic uart_tx_baud_tick,
   input wire logic adc_start_trigger,
   input wire logic smbus_timing_tick
);
   logic [7:0] c2;
   logic c3;
   logic w2;
   assign w2 = sfr_wr && sfr_addr == 8'hC8;
   // Mirror of the software-written control bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c2 <= 8'h00;
         c3 <= 1'b0;
      end else begin
         if (w2) c2 <= sfr_wdata;
         if (sfr_wr && sfr_addr == 8'h91) c3 <= sfr_wdata[2];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_quiet: assert property ($rose(rst_n) |-> !(second_timer_irq ||
      adc_start_trigger || uart_rx_baud_tick || uart_tx_baud_tick))
      else $error("output active after reset");
   a_smb_adc_same: assert property (adc_start_trigger == smbus_timing_tick)
      else $error("timer3 event outputs differ");
   a_adc_needs_run: assert property (adc_start_trigger |->
      $past(c3) || $past(c3, 2) || $past(c3, 3)) else $error("timer3 event while off");
   a_rx_tick_mode: assert property (uart_rx_baud_tick |-> $past(c2[5] && c2[2]))
      else $error("rx tick outside baud mode");
   a_tx_tick_mode: assert property (uart_tx_baud_tick |-> $past(c2[4] && c2[2]))
      else $error("tx tick outside baud mode");
   a_tick_single: assert property (uart_rx_baud_tick |=> !uart_rx_baud_tick)
      else $error("rx tick wider than one cycle");
   a_flag_sticky: assert property (!w2 ##1 (second_timer_irq && !w2) ##1 !w2
      |-> second_timer_irq) else $error("flag cleared without write");
   a_ctrl_readback: assert property ($past(sfr_addr) == 8'hC8 |->
      sfr_rdata[5:0] == $past(c2[5:0])) else $error("control bits read back wrong");
endmodule
bind tmr_pair tmr_chk tmr_chk_i (.*);

// *** verif/tmr_pair_tb.sv ***
// Self-checking bench for the timer pair
`timescale 1ns/1ps
module tmr_pair_tb;
   logic clk = 0, rst_n = 0, sfr_wr = 0, external_count_input = 1;
   logic external_trigger_input = 1;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
   logic second_timer_irq, uart_rx_baud_tick, uart_tx_baud_tick;
   logic adc_start_trigger, smbus_timing_tick;
   logic [15:0] v, r, c;
   logic [7:0] adr[12] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h8E, 8'h91, 8'h92,
      8'h93, 8'h94, 8'h95, 8'h90};
   int n_mismatch = 0, compares = 0, n_rx, n_tx, n_adc, n_smb, k;
   tmr_pair tmr_pair_i (.*);
   always #5 clk = ~clk;
   // Event tallies
   always @(posedge clk) begin
      n_rx += int'(uart_rx_baud_tick === 1'b1);
      n_tx += int'(uart_tx_baud_tick === 1'b1);
      n_adc += int'(adc_start_trigger === 1'b1);
      n_smb += int'(smbus_timing_tick === 1'b1);
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic rng(input logic [15:0] g, input int lo, input int hi, input string m);
      compares++;
      if (g < lo || g > hi || $isunknown(g)) begin
         n_mismatch++;
         $display("ERROR t=%0t %s got %0d want %0d..%0d", $time, m, g, lo, hi);
      end
   endtask
   // Expected events in a span of clock edges for a given period
   function automatic int exp_events(input int edges, input int period);
      return edges / period;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = x;
      sfr_wr = 1;
      @(negedge clk);
      sfr_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      sfr_addr = a;
      @(negedge clk);
      d = sfr_rdata;
   endtask
   task automatic w16(input logic [7:0] a, input logic [15:0] x);
      wr(a, x[7:0]);
      wr(a + 8'h01, x[15:8]);
   endtask
   task automatic r16(input logic [7:0] a);
      rd(a);
      r[7:0] = d;
      rd(a + 8'h01);
      r[15:8] = d;
   endtask
   // Falling edges on trigger or count pin, three cycles low and high
   task automatic pulse(input bit t, input int n);
      repeat (n) begin
         if (t) external_trigger_input = 0;
         else external_count_input = 0;
         repeat (3) @(negedge clk);
         external_trigger_input = 1;
         external_count_input = 1;
         repeat (3) @(negedge clk);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #100000;
      n_mismatch++;
      $display("ERROR t=%0t watchdog expired", $time);
      finish_test();
   end
   // Main sequence
   initial begin
      void'($urandom(57576));
      repeat (20) @(negedge clk);
      rst_n = 1;
      foreach (adr[i]) begin
         rd(adr[i]);
         chk(d, 0, "reset value");
      end
      // Timer mode at both divide settings
      for (int i = 0; i < 2; i++) begin
         v = 16'($urandom_range(32767));
         w16(8'hCC, v);
         wr(8'h8E, i ? 8'h00 : 8'h20);
         wr(8'hC8, 8'h04);
         repeat (i ? 120 : 50) @(negedge clk);
         wr(8'hC8, 8'h00);
         r16(8'hCC);
         k = exp_events(i ? 122 : 52, i ? 12 : 1);
         if (i) rng(r - v, k - 1, k + 1, "div12 count");
         else rng(r - v, k - 1, k + 1, "div1 count");
      end
      // Overflow with reload, flag and clear
      c = 16'($urandom_range(61440));
      w16(8'hCA, c);
      w16(8'hCC, 16'hFFF8);
      wr(8'h8E, 8'h20);
      wr(8'hC8, 8'h04);
      repeat (20) @(negedge clk);
      wr(8'hC8, 8'h80);
      r16(8'hCC);
      rng(r - c, 12, 15, "reload count");
      rd(8'hC8);
      chk(d, 8'h80, "overflow flag");
      chk(second_timer_irq, 1, "irq on overflow");
      wr(8'hC8, 8'h00);
      rd(8'hC8);
      chk({d, 7'h00, second_timer_irq}, 0, "flag clear");
      // Capture ignored without enable, then taken
      v = 16'($urandom_range(32767));
      w16(8'hCC, v);
      wr(8'hC8, 8'h05);
      pulse(1, 1);
      r16(8'hCA);
      chk(r, c, "capture while disabled");
      wr(8'hC8, 8'h0D);
      pulse(1, 1);
      wr(8'hC8, 8'h49);
      rd(8'hC8);
      chk(d, 8'h49, "external flag");
      r16(8'hCA);
      rng(r - v, 3, 40, "captured count");
      wr(8'hC8, 8'h00);
      // Counter mode on count pin edges
      w16(8'hCC, 16'h0000);
      wr(8'hC8, 8'h06);
      k = $urandom_range(8, 3);
      pulse(0, k);
      wr(8'hC8, 8'h00);
      r16(8'hCC);
      chk(r, 16'(k), "pin edge count");
      // Trigger edge reloads in auto-reload mode and sets the flag
      c = 16'($urandom_range(32767, 256));
      w16(8'hCA, c);
      w16(8'hCC, 16'h0000);
      wr(8'hC8, 8'h0C);
      pulse(1, 1);
      wr(8'hC8, 8'h48);
      rd(8'hC8);
      chk(d, 8'h48, "reload trigger flag");
      r16(8'hCC);
      rng(r - c, 3, 6, "trigger reload count");
      wr(8'hC8, 8'h00);
      // Baud generator, receive then transmit
      w16(8'hCA, 16'hFFF8);
      for (int i = 0; i < 2; i++) begin
         d = i ? 8'h14 : 8'h24;
         w16(8'hCC, 16'hFFF8);
         n_rx = 0;
         n_tx = 0;
         wr(8'hC8, d);
         repeat (160) @(negedge clk);
         rd(8'hC8);
         chk(d, i ? 8'h14 : 8'h24, "no baud overflow flag");
         chk(second_timer_irq, 0, "no baud irq");
         wr(8'hC8, 8'h00);
         k = exp_events(164, 16);
         rng(16'(n_rx), i ? 0 : k - 1, i ? 0 : k + 1, "rx ticks");
         rng(16'(n_tx), i ? k - 1 : 0, i ? k + 1 : 0, "tx ticks");
      end
      // Third timer bytes, no pin counting
      v = 16'($urandom_range(32767));
      w16(8'h94, v);
      r16(8'h94);
      chk(r, v, "timer3 bytes");
      wr(8'h91, 8'h04);
      pulse(0, 3);
      wr(8'h91, 8'h00);
      r16(8'h94);
      rng(r - v, 1, 2, "timer3 ignores pin");
      // Third timer reload at divide one and twelve
      for (int i = 0; i < 2; i++) begin
         c = i ? 16'hFFFE : 16'hFFF0;
         w16(8'h92, c);
         w16(8'h94, c);
         n_adc = 0;
         n_smb = 0;
         wr(8'h91, i ? 8'h04 : 8'h05);
         repeat (i ? 240 : 160) @(negedge clk);
         wr(8'h91, 8'h00);
         k = exp_events(i ? 242 : 162, i ? 24 : 16);
         rng(16'(n_adc), k - 1, k + 1, "timer3 events");
         chk(16'(n_smb), 16'(n_adc), "smbus events");
         r16(8'h92);
         chk(r, c, "timer3 reload bytes");
      end
      finish_test();
   end
endmodule
